/* verilog/bais_consts.svh */
// Constants for the byte ALU slice: widths, reset values, operation codes
`ifndef BAIS_CONSTS_SVH
`define BAIS_CONSTS_SVH
`define BAIS_DATA_W 8
`define BAIS_ADDR_W 7
`define BAIS_FILE_DEPTH 128
`define BAIS_ACC_RESET 8'h00
`define BAIS_FLAG_RESET 1'b0
`define BAIS_ONE 8'h01
`define BAIS_ZERO 8'h00
`define BAIS_MSB 7
`define BAIS_LSB 0
`define BAIS_DEST_ACC 1'b0
`define BAIS_DEST_FILE 1'b1
`define BAIS_OP_W 3
`define BAIS_OP_NONE 3'h0
`define BAIS_OP_INC 3'h1
`define BAIS_OP_INC_SKIP 3'h2
`define BAIS_OP_OR_LIT 3'h3
`define BAIS_OP_OR_FILE 3'h4
`define BAIS_OP_LSL 3'h5
`define BAIS_OP_LSR 3'h6
`endif

/* verilog/bais_pkg.sv */
// Types for the byte ALU slice
`include "bais_consts.svh"
package bais_pkg;
  typedef enum logic [2:0] {
    bais_st_fetch_type = 3'h1,
    bais_st_read_type = 3'h2,
    bais_st_skip_type = 3'h4
  } bais_state_type;
  typedef struct packed {
    bais_state_type state;
    logic [`BAIS_OP_W-1:0] op;
    logic dest;
    logic [`BAIS_ADDR_W-1:0] addr;
    logic [`BAIS_DATA_W-1:0] lit;
    logic [`BAIS_DATA_W-1:0] acc;
    logic carry;
    logic zero;
    logic ready;
    logic done;
    logic skip;
  } bais_core_type;
endpackage : bais_pkg

/* verilog/bais_file_mem.sv */
// File register memory with registered read data
`timescale 1ns/1ps
module bais_file_mem #(
  parameter int DATA_W = 8,
  parameter int ADDR_W = 7,
  parameter int DEPTH = 128
) (
  // Clock
  input wire logic clock,
  input wire logic clk_en,
  // Read port
  input wire logic [ADDR_W-1:0] rd_addr,
  output logic [DATA_W-1:0] rd_data,
  // Write port
  input wire logic wr_en,
  input wire logic [ADDR_W-1:0] wr_addr,
  input wire logic [DATA_W-1:0] wr_data
);
  logic [DATA_W-1:0] mem [0:DEPTH-1];
  initial begin
    if (DEPTH > (1 << ADDR_W)) $error("bais_file_mem: depth exceeds address range");
  end
  // Contents are not reset; software initialises file registers as in the core
  always_ff @(posedge clock) begin
    if (clk_en) begin
      if (wr_en) begin
        mem[wr_addr] <= wr_data;
      end
      rd_data <= mem[rd_addr];
    end
  end
endmodule : bais_file_mem

/* verilog/bais_top.sv */
// Byte ALU slice: increment, increment-skip, OR and logical shifts
//
// Overview of operation
// - File ops take 7-bit address 0..127; d=0 to accumulator, d=1 to file.
// - Increment adds one to file value, writes destination, updates zero flag.
// - Increment-skip stores sum, flags untouched; zero result squashes next instruction.
// - OR literal: accumulator OR 8-bit immediate into accumulator, update zero.
// - OR file: accumulator OR file value into chosen destination, update zero.
// - Left shift: bit 7 to carry, bits 6:0 up one, zero in; carry, zero.
// - Right shift: zero into bit 7, bits 7:1 down one, bit 0 to carry.
`timescale 1ns/1ps
module bais_top
  import bais_pkg::*;
#(
  parameter int DATA_W = `BAIS_DATA_W,
  parameter int ADDR_W = `BAIS_ADDR_W,
  parameter int DEPTH = `BAIS_FILE_DEPTH
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  input wire logic clk_en,
  // Instruction issue
  input wire logic op_valid,
  input wire logic [`BAIS_OP_W-1:0] op_code,
  input wire logic op_dest,
  input wire logic [ADDR_W-1:0] op_addr,
  input wire logic [DATA_W-1:0] op_literal,
  // Status and results
  output logic op_ready,
  output logic op_done,
  output logic skip_next,
  output logic [DATA_W-1:0] acc_value,
  output logic carry_flag,
  output logic zero_flag
);
  initial begin
    // The shift and flag logic are written for a byte and a 7-bit file address
    if (DATA_W != `BAIS_DATA_W) $error("bais_top: data width must be 8");
    if (ADDR_W != `BAIS_ADDR_W) $error("bais_top: address width must be 7");
    if (DEPTH > (1 << ADDR_W) || DEPTH < 1) $error("bais_top: bad file depth");
  end

  ////////////////////////////////////////////////////////////////////////////
  bais_core_type core_q;
  bais_core_type core_d;
  logic [DATA_W-1:0] file_rd;
  logic file_we;
  logic [DATA_W-1:0] result;
  logic [DATA_W-1:0] inc_sum;
  logic [DATA_W-1:0] or_lit;
  logic [DATA_W-1:0] or_file;
  logic [DATA_W-1:0] shl_val;
  logic [DATA_W-1:0] shr_val;
  // Decoded view of the latched operation
  logic op_known;
  logic op_is_skip;
  logic op_is_shift;
  logic to_acc;
  logic to_file;
  logic updates_zero;
  logic updates_carry;
  logic carry_next;
  logic result_zero;
  logic take_issue;
  logic skip_taken;

  // Address presented at issue so read data is ready in the read state
  bais_file_mem #(
    .DATA_W(DATA_W),
    .ADDR_W(ADDR_W),
    .DEPTH(DEPTH)
  ) u_file (
    .clock(clock),
    .clk_en(clk_en),
    .rd_addr(op_addr),
    .rd_data(file_rd),
    .wr_en(file_we),
    .wr_addr(core_q.addr),
    .wr_data(result)
  );

  ////////////////////////////////////////////////////////////////////////////
  // All candidate results are formed in parallel; the latched op picks one
  assign inc_sum = file_rd + `BAIS_ONE;
  assign or_lit = core_q.acc | core_q.lit;
  assign or_file = core_q.acc | file_rd;
  assign shl_val = {file_rd[`BAIS_MSB-1:`BAIS_LSB], 1'b0};
  assign shr_val = {1'b0, file_rd[`BAIS_MSB:`BAIS_LSB+1]};
  // Codes 0 and 7 are accepted and retired with no effect beyond the done pulse
  assign op_known = (core_q.op == `BAIS_OP_INC) ||
    (core_q.op == `BAIS_OP_INC_SKIP) ||
    (core_q.op == `BAIS_OP_OR_LIT) ||
    (core_q.op == `BAIS_OP_OR_FILE) ||
    (core_q.op == `BAIS_OP_LSL) ||
    (core_q.op == `BAIS_OP_LSR);
  assign op_is_skip = (core_q.op == `BAIS_OP_INC_SKIP);
  assign op_is_shift = (core_q.op == `BAIS_OP_LSL) || (core_q.op == `BAIS_OP_LSR);
  // The literal form has no file operand, so its destination bit is ignored
  // destination select
  assign to_acc = op_known &&
    ((core_q.op == `BAIS_OP_OR_LIT) || (core_q.dest == `BAIS_DEST_ACC));
  assign to_file = op_known && !to_acc;
  assign result_zero = (result == `BAIS_ZERO);
  assign updates_zero = op_known && !op_is_skip;
  assign updates_carry = op_is_shift;
  assign carry_next = (core_q.op == `BAIS_OP_LSR) ? file_rd[`BAIS_LSB] : file_rd[`BAIS_MSB];
  assign skip_taken = op_is_skip && result_zero;
  // Issue is taken only while idle in the fetch state
  assign take_issue = op_valid && (core_q.state == bais_st_fetch_type);

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    core_d = core_q;
    core_d.done = 1'b0;
    file_we = 1'b0;
    result = `BAIS_ZERO;
    case (core_q.op)
      `BAIS_OP_INC: result = inc_sum;
      `BAIS_OP_INC_SKIP: result = inc_sum;
      `BAIS_OP_OR_LIT: result = or_lit;
      `BAIS_OP_OR_FILE: result = or_file;
      `BAIS_OP_LSL: result = shl_val;
      `BAIS_OP_LSR: result = shr_val;
      default: result = `BAIS_ZERO;
    endcase

    // Sequencer: fetch, read and commit, optional no-op cycle
    case (core_q.state)
      bais_st_fetch_type: begin
        core_d.skip = 1'b0;
        if (take_issue) begin
          core_d.op = op_code;
          core_d.dest = op_dest;
          core_d.addr = op_addr;
          core_d.lit = op_literal;
          core_d.ready = 1'b0;
          core_d.state = bais_st_read_type;
        end
      end
      bais_st_read_type: begin
        core_d.done = 1'b1;
        core_d.ready = 1'b1;
        core_d.state = bais_st_fetch_type;
        if (to_acc) begin
          core_d.acc = result;
        end
        // A write in flight when reset arrives is dropped with the rest of the op
        if (to_file && !rst) begin
          file_we = 1'b1;
        end
        if (updates_zero) begin
          core_d.zero = result_zero;
        end
        if (updates_carry) begin
          core_d.carry = carry_next;
        end
        if (skip_taken) begin
          core_d.skip = 1'b1;
          core_d.ready = 1'b0;
          core_d.state = bais_st_skip_type;
        end
      end
      bais_st_skip_type: begin
        // Forced no-operation cycle; the squashed instruction is never taken
        core_d.skip = 1'b0;
        core_d.ready = 1'b1;
        core_d.state = bais_st_fetch_type;
      end
      default: begin
        core_d.state = bais_st_fetch_type;
        core_d.skip = 1'b0;
        core_d.ready = 1'b1;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    // Reset acts even while the clock enable is low
    if (rst) begin
      core_q.state <= bais_st_fetch_type;
      core_q.op <= `BAIS_OP_NONE;
      core_q.dest <= `BAIS_DEST_ACC;
      core_q.addr <= '0;
      core_q.lit <= `BAIS_ZERO;
      core_q.acc <= `BAIS_ACC_RESET;
      core_q.carry <= `BAIS_FLAG_RESET;
      core_q.zero <= `BAIS_FLAG_RESET;
      core_q.ready <= 1'b1;
      core_q.done <= 1'b0;
      core_q.skip <= 1'b0;
    end else if (clk_en) begin
      core_q <= core_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  assign op_ready = core_q.ready;
  assign op_done = core_q.done;
  assign skip_next = core_q.skip;
  assign acc_value = core_q.acc;
  assign carry_flag = core_q.carry;
  assign zero_flag = core_q.zero;
endmodule : bais_top

/* bench/bais_chk.sv */
// Port assertions for the byte ALU slice
`timescale 1ns/1ps
module bais_chk (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  input wire logic clk_en,
  // Issue
  input wire logic op_valid,
  input wire logic [2:0] op_code,
  input wire logic op_dest,
  input wire logic [7:0] op_literal,
  // Results
  input wire logic op_ready,
  input wire logic op_done,
  input wire logic skip_next,
  input wire logic [7:0] acc_value,
  input wire logic carry_flag,
  input wire logic zero_flag
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  sequence s_take;
    op_valid && op_ready && clk_en;
  endsequence
  sequence s_acc(c);
    s_take ##0 (op_code == c && !op_dest);
  endsequence
  property p_time;
    s_take |-> ##1 !op_ready ##1 op_done;
  endproperty
  a_time: assert property (p_time) else $error("done late");
  property p_dest;
    s_take ##0 (op_dest && op_code != 3'h3) |-> ##2 acc_value == $past(acc_value, 2);
  endproperty
  a_dest: assert property (p_dest) else $error("acc changed");
  property p_skf;
    s_take ##0 op_code == 3'h2 |-> ##2 $stable(zero_flag) && carry_flag == $past(carry_flag, 2);
  endproperty
  a_skf: assert property (p_skf) else $error("flags moved");
  property p_lit;
    s_take ##0 op_code == 3'h3 |-> ##2 acc_value == ($past(acc_value, 2) | $past(op_literal, 2));
  endproperty
  a_lit: assert property (p_lit) else $error("bad literal or");
  property p_orf;
    s_acc(3'h4) |-> ##2 (acc_value | $past(acc_value, 2)) == acc_value;
  endproperty
  a_orf: assert property (p_orf) else $error("bad file or");
  property p_lsl;
    s_acc(3'h5) |-> ##2 !acc_value[0];
  endproperty
  a_lsl: assert property (p_lsl) else $error("bad left fill");
  property p_lsr;
    s_acc(3'h6) |-> ##2 !acc_value[7];
  endproperty
  a_lsr: assert property (p_lsr) else $error("bad right fill");
  property p_zero;
    s_take ##0 (op_code == 3'h3 || !op_dest && op_code inside {3'h1, 3'h4, 3'h5, 3'h6})
      |-> ##2 zero_flag == (acc_value == 8'h00);
  endproperty
  a_zero: assert property (p_zero) else $error("bad zero");
  sequence s_squash;
    op_done && skip_next && !op_ready;
  endsequence
  sequence s_resume;
    !skip_next && op_ready && !op_done;
  endsequence
  property p_skip;
    skip_next |-> s_squash ##1 s_resume;
  endproperty
  a_skip: assert property (p_skip) else $error("bad skip cycle");
endmodule : bais_chk
bind bais_top bais_chk chk_u (.clock(clock), .rst(rst), .clk_en(clk_en), .op_valid(op_valid),
  .op_code(op_code), .op_dest(op_dest), .op_literal(op_literal), .op_ready(op_ready),
  .op_done(op_done), .skip_next(skip_next), .acc_value(acc_value), .carry_flag(carry_flag),
  .zero_flag(zero_flag));

/* bench/testbench.sv */
// Self-checking bench for the byte ALU slice
`timescale 1ns/1ps
module testbench;
  logic clock = 1'b0, rst = 1'b1, op_valid = 1'b0, op_dest = 1'b0, clk_en = 1'b1;
  logic [2:0] op_code = 3'h0;
  logic [6:0] op_addr = 7'h00;
  logic [7:0] op_literal = 8'h00, acc_value, acc_m, fm [128];
  logic op_ready, op_done, skip_next, carry_flag, zero_flag, cy_m, z_m;
  int miscompares = 0, checked = 0;
  bais_top dut_u (.clock(clock), .rst(rst), .clk_en(clk_en), .op_valid(op_valid),
    .op_code(op_code), .op_dest(op_dest), .op_addr(op_addr), .op_literal(op_literal),
    .op_ready(op_ready), .op_done(op_done), .skip_next(skip_next), .acc_value(acc_value),
    .carry_flag(carry_flag), .zero_flag(zero_flag));
  initial forever #12.5 clock = ~clock;
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if ($isunknown(exp) || got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic final_report();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : final_report
  task automatic do_op(input logic [2:0] c, input logic d, input logic [6:0] a,
    input logic [7:0] k);
    logic [7:0] r;
    logic cy;
    r = fm[a] + 8'h01;
    cy = cy_m;
    case (c)
      3'h3: r = acc_m | k;
      3'h4: r = acc_m | fm[a];
      3'h5: {cy, r} = {fm[a], 1'b0};
      3'h6: {r, cy} = {1'b0, fm[a]};
      default: ;
    endcase
    @(posedge clock);
    op_valid <= 1'b1;
    op_code <= c;
    op_dest <= d;
    op_addr <= a;
    op_literal <= k;
    @(posedge clock);
    op_valid <= 1'b0;
    #1;
    // Cycle after the take: busy, nothing retired yet
    chk({6'h00, op_ready, op_done}, 8'h00);
    @(posedge clock);
    #1;
    if (d && c != 3'h3) begin
      fm[a] = r;
    end else begin
      acc_m = r;
    end
    if (c != 3'h2) begin
      z_m = r == 8'h00;
    end
    cy_m = cy;
    if (!$isunknown({r, cy})) begin
      chk({7'h00, op_done}, 8'h01);
      chk(acc_value, acc_m);
      chk({6'h00, carry_flag, zero_flag}, {6'h00, cy_m, z_m});
      chk({7'h00, skip_next}, {7'h00, c == 3'h2 && r == 8'h00});
      chk({7'h00, op_ready}, {7'h00, !(c == 3'h2 && r == 8'h00)});
    end
    if (c == 3'h2 && r == 8'h00) begin
      @(posedge clock);
      #1;
      chk({6'h00, skip_next, op_ready}, 8'h01);
    end
  endtask : do_op
  task automatic t_reset();
    @(posedge clock);
    rst <= 1'b1;
    @(posedge clock);
    rst <= 1'b0;
    #1;
    {acc_m, cy_m, z_m} = 10'h000;
    chk(acc_value, 8'h00);
    chk({3'h0, carry_flag, zero_flag, op_ready, op_done, skip_next}, 8'h04);
    do_op(3'h3, 1'b0, 7'h00, 8'h00);
    $display("reset test done");
  endtask : t_reset
  task automatic t_clear();
    // Nine left shifts into each of file cells 00 and 7F flush any power-up contents out of them
    for (int i = 0; i < 18; i++) begin
      do_op(3'h5, 1'b1, i[0] ? 7'h7F : 7'h00, 8'h00);
    end
    // File cells are known from here on, so the file OR is judged fully
    do_op(3'h4, 1'b0, 7'h00, 8'h00);
    do_op(3'h4, 1'b0, 7'h7F, 8'h00);
    $display("clear test done");
  endtask : t_clear
  task automatic t_ops();
    do_op(3'h3, 1'b0, 7'h00, 8'hA5);
    do_op(3'h4, 1'b1, 7'h7F, 8'h00);
    do_op(3'h3, 1'b0, 7'h00, 8'h5A);
    do_op(3'h4, 1'b1, 7'h00, 8'h00);
    do_op(3'h1, 1'b0, 7'h00, 8'h00);
    do_op(3'h2, 1'b1, 7'h00, 8'h00);
    do_op(3'h2, 1'b0, 7'h00, 8'h00);
    do_op(3'h1, 1'b1, 7'h00, 8'h00);
    do_op(3'h5, 1'b0, 7'h7F, 8'h00);
    do_op(3'h6, 1'b0, 7'h7F, 8'h00);
    do_op(3'h6, 1'b1, 7'h00, 8'h00);
    do_op(3'h5, 1'b1, 7'h7F, 8'h00);
    do_op(3'h6, 1'b0, 7'h7F, 8'h00);
    do_op(3'h3, 1'b1, 7'h00, 8'h10);
    $display("ops test done");
  endtask : t_ops
  task automatic t_freeze();
    @(posedge clock);
    clk_en <= 1'b0;
    op_valid <= 1'b1;
    op_code <= 3'h3;
    op_dest <= 1'b0;
    op_literal <= 8'hC3;
    repeat (3) @(posedge clock);
    #1;
    // With the enable low the request is never taken and nothing moves
    chk(acc_value, acc_m);
    chk({6'h00, op_ready, op_done}, 8'h02);
    @(posedge clock);
    op_valid <= 1'b0;
    clk_en <= 1'b1;
    $display("freeze test done");
  endtask : t_freeze
  initial begin
    repeat (3000) @(posedge clock);
    miscompares++;
    final_report();
  end
  initial begin
    t_reset();
    t_clear();
    t_ops();
    t_freeze();
    t_reset();
    final_report();
  end
endmodule : testbench
